// file: rtl/uart_control_one_and_map.v
`timescale 1ns/1ps
`include "uart_defs.vh"
// Function
// R1: Clearing unit_on aborts transfers and stops prescaler and outputs immediately.
// R2: Unit disable keeps configuration but returns status flags to reset state.
// R3: receiver_on set makes receiver hunt for start bit; clear stops reception.
// R4: transmitter_on turns the transmitter on or off.
// R5: idle_irq_on raises interrupt while idle_seen_flag is set.
// R6: rx_full_irq_on raises interrupt on overrun_flag or rx_full_flag.
// R7: tx_done_irq_on raises interrupt when tx_done_flag is set.
// R8: tx_empty_irq_on raises interrupt when tx_empty_flag is set.
// R9: parity_err_irq_on raises interrupt when parity_err_flag is set.
// R10: parity_sense even or odd, applied only from the next frame.
// R11: parity_on puts parity in top data bit and checks it on receive.
// R12: wakeup_method leaves mute on idle line or on address byte.
// R13: nine_bit_select picks eight or nine data bits; held per frame.
// R14: mute_allow lets the receiver switch between normal and mute.
// R15: char_match_irq_on raises interrupt when char_match_flag is set.
// R16: oversample_select picks sixteen or eight samples per bit.
// R17: driver_release_delay samples from last stop bit to driver release.
// R18: Data written during release delay waits for release then assert delay.
// R19: driver_assert_delay samples from driver on to first start bit.
// R20: Software changes frame settings only while unit_on is clear.
// R21: Register offsets as mapped, control one at 0x00 to transmit at 0x28.
// R22: Control one reads all zeros after reset.
// R23: line_driver_on output enables external transceiver during transmission.
// R24: All enabled interrupt sources ORed into one request line.
// R25: Reserved control one bits read zero and ignore writes.
module uart_control_one_and_map (
	// Clock, reset, enable
	input  wire        core_clk,
	input  wire        reset_n,
	input  wire        clk_en,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Serial line
	input  wire        rx_line,
	output reg         tx_line,
	output reg         line_driver_on,
	// Interrupt request
	output reg         irq
);
	localparam T_IDLE = 3'd0, T_LEAD = 3'd1, T_START = 3'd2, T_DATA = 3'd3, T_STOP = 3'd4, T_LAG = 3'd5;
	localparam R_IDLE = 2'd0, R_START = 2'd1, R_DATA = 2'd2, R_STOP = 2'd3;

	reg  [31:0] ctrl1_q, ctrl2_q, ctrl3_q, rxto_q;
	reg  [15:0] baud_q, pre_q;
	reg  [8:0]  tbuf_q, tsh_q, rsh_q, rdat_q;
	reg         tx_full_q, rx_full_q, ovr_q, idle_q, done_q, perr_q, cm_q, mute_q;
	reg  [2:0]  ts_q;
	reg  [3:0]  tsc_q, tbit_q;
	reg  [4:0]  tdc_q;
	reg         t_nine_q;
	reg  [1:0]  rs_q;
	reg  [3:0]  rsc_q, rbit_q, icnt_q;
	reg         r_nine_q, r_par_q, r_sense_q, iarm_q;
	reg  [31:0] rdata_d;
	reg         err_d;

	wire unit_on   = ctrl1_q[`C1_UNIT_ON];
	wire nine      = ctrl1_q[`C1_NINE_BIT_SELECT];
	wire par_on    = ctrl1_q[`C1_PARITY_ON];
	wire sense     = ctrl1_q[`C1_PARITY_SENSE];
	wire de_func   = ctrl3_q[`C3_DRIVER_FUNC];
	wire [4:0] rel_dly = ctrl1_q[`C1_RELEASE_LSB +: 5];
	wire [4:0] ast_dly = ctrl1_q[`C1_ASSERT_LSB +: 5];
	wire [7:0] match   = ctrl2_q[`C2_MATCH_LSB +: 8];
	wire [3:0] osr_last = ctrl1_q[`C1_OVERSAMPLE_SELECT] ? `OSR8_LAST : `OSR16_LAST; // R16
	wire [3:0] osr_half = ctrl1_q[`C1_OVERSAMPLE_SELECT] ? `OSR8_HALF : `OSR16_HALF; // R16

	// APB completion edge: writes and read side effects happen only here
	wire acc  = psel & penable & pready;
	wire wr   = acc & pwrite;
	wire rd   = acc & ~pwrite;
	wire wr_c1  = wr & (paddr == `OFS_CONTROL_ONE); // R21
	wire wr_tx  = wr & (paddr == `OFS_TRANSMIT_WORD);
	wire wr_clr = wr & (paddr == `OFS_EVENT_FLAG_CLEAR);
	wire wr_rq  = wr & (paddr == `OFS_ACTION_REQUEST);
	wire rd_rx  = rd & (paddr == `OFS_RECEIVED_WORD);

	// Sample tick; prescaler halts with the unit
	wire tick = unit_on & (pre_q >= baud_q); // R1

	// Transmit word with parity in the top data position
	wire [8:0] raw   = tbuf_q;
	wire       t_par = (nine ? ^raw[7:0] : ^raw[6:0]) ^ sense; // R10
	wire [8:0] t_word = par_on ? (nine ? {t_par, raw[7:0]} : {1'b0, t_par, raw[6:0]}) // R11
	                           : (nine ? raw : {1'b0, raw[7:0]}); // R13
	wire t_bit_end = tick & (tsc_q == osr_last);
	wire lead_done = (tdc_q == ast_dly); // R19
	wire lag_done  = (tdc_q == rel_dly); // R17
	wire t_go      = unit_on & ctrl1_q[`C1_TRANSMITTER_ON] & tx_full_q; // R4
	wire t_begin   = t_go & (((ts_q == T_IDLE) & ~de_func) | ((ts_q == T_LEAD) & lead_done));

	// Receive frame decode
	wire r_bit_end = tick & (rsc_q == osr_last);
	wire r_done    = (rs_q == R_STOP) & r_bit_end;
	wire [8:0] r_word = r_nine_q ? rsh_q : {1'b0, rsh_q[8:1]};
	wire r_bad     = r_par_q & ((r_nine_q ? ^r_word[8:0] : ^r_word[7:0]) ^ r_sense_q); // R11
	wire r_addr    = r_nine_q ? r_word[8] : r_word[7];
	wire r_hit     = (r_word[3:0] == match[3:0]);
	wire mute_on   = ctrl1_q[`C1_MUTE_ALLOW] & mute_q; // R14
	wire r_take    = r_done & ~mute_on;
	wire idle_ev   = (rs_q == R_IDLE) & r_bit_end & iarm_q & (icnt_q == `IDLE_BITS_LAST) & rx_line;

	wire [31:0] status = {12'h000, mute_on, 1'b0, cm_q, 9'h000, ~tx_full_q, done_q, rx_full_q,
	                      idle_q, ovr_q, 2'b00, perr_q};

	always @* begin
		rdata_d = 32'h0000_0000;
		err_d   = 1'b0;
		case (paddr)
			`OFS_CONTROL_ONE:      rdata_d = ctrl1_q; // R25
			`OFS_CONTROL_TWO:      rdata_d = ctrl2_q;
			`OFS_CONTROL_THREE:    rdata_d = ctrl3_q;
			`OFS_BAUD_DIVIDER:     rdata_d = {16'h0000, baud_q};
			`OFS_RECEIVE_TIMEOUT:  rdata_d = rxto_q;
			`OFS_ACTION_REQUEST:   rdata_d = 32'h0000_0000;
			`OFS_EVENT_STATE:      rdata_d = status;
			`OFS_EVENT_FLAG_CLEAR: rdata_d = 32'h0000_0000;
			`OFS_RECEIVED_WORD:    rdata_d = {23'h000000, rdat_q};
			`OFS_TRANSMIT_WORD:    rdata_d = {23'h000000, tbuf_q};
			default:               err_d   = 1'b1; // R21
		endcase
	end

	// Bus slave and configuration registers
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl1_q <= `C1_RESET; // R22
			ctrl2_q <= 32'h0000_0000;
			ctrl3_q <= 32'h0000_0000;
			baud_q  <= 16'h0000;
			rxto_q  <= 32'h0000_0000;
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			// One wait state keeps prdata registered
			pready  <= psel & penable & ~pready;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata_d : 32'h0000_0000;
			pslverr <= psel & penable & ~pready & err_d;
			if (wr_c1)
				ctrl1_q <= pwdata & `C1_WRITE_MASK; // R25
			if (wr & (paddr == `OFS_CONTROL_TWO))
				ctrl2_q <= pwdata;
			if (wr & (paddr == `OFS_CONTROL_THREE))
				ctrl3_q <= pwdata;
			if (wr & (paddr == `OFS_BAUD_DIVIDER))
				baud_q <= pwdata[15:0];
			if (wr & (paddr == `OFS_RECEIVE_TIMEOUT))
				rxto_q <= pwdata;
		end
	end

	// Prescaler
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_q <= 16'h0000;
		end else if (clk_en) begin
			if (!unit_on | tick)
				pre_q <= 16'h0000; // R1
			else
				pre_q <= pre_q + 16'h0001;
		end
	end

	// Transmitter
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ts_q           <= T_IDLE;
			tsc_q          <= 4'h0;
			tbit_q         <= 4'h0;
			tdc_q          <= 5'h00;
			tsh_q          <= 9'h000;
			t_nine_q       <= 1'b0;
			tx_line        <= 1'b1;
			line_driver_on <= 1'b0;
		end else if (clk_en) begin
			if (!unit_on) begin
				ts_q           <= T_IDLE; // R1
				tx_line        <= 1'b1;
				line_driver_on <= 1'b0;
			end else if (t_begin) begin
				ts_q     <= T_START;
				tsc_q    <= 4'h0;
				tsh_q    <= t_word;
				t_nine_q <= nine; // R13
				tx_line  <= 1'b0;
			end else begin
				if (tick)
					tsc_q <= (tsc_q == osr_last) ? 4'h0 : tsc_q + 4'h1;
				case (ts_q)
					T_IDLE: begin
						if (t_go & de_func) begin
							ts_q           <= T_LEAD;
							tdc_q          <= 5'h00;
							line_driver_on <= 1'b1; // R23
						end
					end
					T_LEAD: begin
						// Transmitter dropped before the start bit: hand the line back
						if (!t_go) begin
							ts_q           <= T_IDLE; // R4
							line_driver_on <= 1'b0;
						end else if (tick) begin
							tdc_q <= tdc_q + 5'h01; // R19
						end
					end
					T_START, T_DATA: begin
						if (t_bit_end) begin
							tbit_q  <= (ts_q == T_START) ? 4'h0 : tbit_q + 4'h1;
							if ((ts_q == T_DATA) & (tbit_q == (t_nine_q ? 4'h8 : 4'h7))) begin
								ts_q    <= T_STOP;
								tx_line <= 1'b1;
							end else begin
								ts_q    <= T_DATA;
								tx_line <= tsh_q[0];
								tsh_q   <= {1'b0, tsh_q[8:1]};
							end
						end
					end
					T_STOP: begin
						if (t_bit_end) begin
							tdc_q <= 5'h00;
							ts_q  <= de_func ? T_LAG : T_IDLE;
						end
					end
					T_LAG: begin
						if (lag_done) begin
							tdc_q <= 5'h00;
							if (t_go) begin
								ts_q <= T_LEAD; // R18
							end else begin
								ts_q           <= T_IDLE;
								line_driver_on <= 1'b0; // R17
							end
						end else if (tick) begin
							tdc_q <= tdc_q + 5'h01;
						end
					end
					default: ts_q <= T_IDLE;
				endcase
			end
		end
	end

	// Receiver
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rs_q      <= R_IDLE;
			rsc_q     <= 4'h0;
			rbit_q    <= 4'h0;
			rsh_q     <= 9'h000;
			r_nine_q  <= 1'b0;
			r_par_q   <= 1'b0;
			r_sense_q <= 1'b0;
			icnt_q    <= 4'h0;
			iarm_q    <= 1'b0;
		end else if (clk_en) begin
			if (!unit_on | !ctrl1_q[`C1_RECEIVER_ON]) begin
				rs_q   <= R_IDLE; // R3
				iarm_q <= 1'b0;
			end else begin
				if (tick)
					rsc_q <= (rsc_q == osr_last) ? 4'h0 : rsc_q + 4'h1;
				case (rs_q)
					R_IDLE: begin
						if (!rx_line) begin
							rs_q      <= R_START; // R3
							rsc_q     <= 4'h0;
							icnt_q    <= 4'h0;
							r_nine_q  <= nine;
							r_par_q   <= par_on; // R10
							r_sense_q <= sense;
						end else if (r_bit_end) begin
							icnt_q <= (icnt_q == `IDLE_BITS_LAST) ? icnt_q : icnt_q + 4'h1;
							if (idle_ev)
								iarm_q <= 1'b0;
						end
					end
					R_START: begin
						// Re-centre sampling on mid bit; a short glitch is ignored
						if (tick & (rsc_q == osr_half)) begin
							rs_q   <= rx_line ? R_IDLE : R_DATA;
							rsc_q  <= 4'h0;
							rbit_q <= 4'h0;
						end
					end
					R_DATA: begin
						if (r_bit_end) begin
							rsh_q  <= {rx_line, rsh_q[8:1]};
							rbit_q <= rbit_q + 4'h1;
							if (rbit_q == (r_nine_q ? 4'h8 : 4'h7))
								rs_q <= R_STOP;
						end
					end
					R_STOP: begin
						if (r_bit_end) begin
							rs_q   <= R_IDLE;
							iarm_q <= 1'b1;
						end
					end
					default: rs_q <= R_IDLE;
				endcase
			end
		end
	end

	// Status flags: hardware set wins over software clear
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tbuf_q    <= 9'h000;
			tx_full_q <= 1'b0;
			rx_full_q <= 1'b0;
			rdat_q    <= 9'h000;
			ovr_q     <= 1'b0;
			idle_q    <= 1'b0;
			done_q    <= 1'b0;
			perr_q    <= 1'b0;
			cm_q      <= 1'b0;
			mute_q    <= 1'b0;
			irq       <= 1'b0;
		end else if (clk_en) begin
			if (wr_tx)
				tbuf_q <= pwdata[8:0];
			if (!unit_on) begin
				tx_full_q <= 1'b0; // R2
				rx_full_q <= 1'b0;
				ovr_q     <= 1'b0;
				idle_q    <= 1'b0;
				done_q    <= 1'b0;
				perr_q    <= 1'b0;
				cm_q      <= 1'b0;
				mute_q    <= 1'b0;
			end else begin
				tx_full_q <= wr_tx | (tx_full_q & ~t_begin);
				if (r_take & ~rx_full_q)
					rdat_q <= r_word;
				rx_full_q <= r_take | (rx_full_q & ~rd_rx & ~(wr_rq & pwdata[`RQ_RX_FLUSH]));
				ovr_q  <= (r_take & rx_full_q) | (ovr_q & ~(wr_clr & pwdata[`ST_OVERRUN]));
				idle_q <= (idle_ev & ~mute_on) | (idle_q & ~(wr_clr & pwdata[`ST_IDLE_SEEN]));
				perr_q <= (r_take & r_bad) | (perr_q & ~(wr_clr & pwdata[`ST_PARITY_ERR]));
				cm_q   <= (r_take & (r_word[7:0] == match)) | (cm_q & ~(wr_clr & pwdata[`ST_CHAR_MATCH]));
				done_q <= ((ts_q == T_STOP) & t_bit_end & ~tx_full_q)
				          | (done_q & ~(wr_clr & pwdata[`ST_TX_DONE]));
				// Mute entry by request or by a non-matching address; exit by idle line or matching address
				if (!ctrl1_q[`C1_MUTE_ALLOW])
					mute_q <= 1'b0; // R14
				else if (ctrl1_q[`C1_WAKEUP_METHOD] & r_done & r_addr)
					mute_q <= ~r_hit; // R12
				else if (!ctrl1_q[`C1_WAKEUP_METHOD] & idle_ev)
					mute_q <= 1'b0; // R12
				else if (wr_rq & pwdata[`RQ_MUTE])
					mute_q <= 1'b1;
			end
			irq <= unit_on & ((ctrl1_q[`C1_IDLE_IRQ_ON] & idle_q) // R5 R24
			       | (ctrl1_q[`C1_RX_FULL_IRQ_ON] & (ovr_q | rx_full_q)) // R6
			       | (ctrl1_q[`C1_TX_DONE_IRQ_ON] & done_q) // R7
			       | (ctrl1_q[`C1_TX_EMPTY_IRQ_ON] & ~tx_full_q) // R8
			       | (ctrl1_q[`C1_PARITY_ERR_IRQ_ON] & perr_q) // R9
			       | (ctrl1_q[`C1_CHAR_MATCH_IRQ_ON] & cm_q)); // R15
		end
	end
endmodule

// file: rtl/uart_defs.vh
`ifndef UART_DEFS_VH
`define UART_DEFS_VH
// Register byte offsets
`define OFS_CONTROL_ONE      8'h00
`define OFS_CONTROL_TWO      8'h04
`define OFS_CONTROL_THREE    8'h08
`define OFS_BAUD_DIVIDER     8'h0c
`define OFS_RECEIVE_TIMEOUT  8'h14
`define OFS_ACTION_REQUEST   8'h18
`define OFS_EVENT_STATE      8'h1c
`define OFS_EVENT_FLAG_CLEAR 8'h20
`define OFS_RECEIVED_WORD    8'h24
`define OFS_TRANSMIT_WORD    8'h28
// Control one fields
`define C1_UNIT_ON           0
`define C1_RECEIVER_ON       2
`define C1_TRANSMITTER_ON    3
`define C1_IDLE_IRQ_ON       4
`define C1_RX_FULL_IRQ_ON    5
`define C1_TX_DONE_IRQ_ON    6
`define C1_TX_EMPTY_IRQ_ON   7
`define C1_PARITY_ERR_IRQ_ON 8
`define C1_PARITY_SENSE      9
`define C1_PARITY_ON         10
`define C1_WAKEUP_METHOD     11
`define C1_NINE_BIT_SELECT   12
`define C1_MUTE_ALLOW        13
`define C1_CHAR_MATCH_IRQ_ON 14
`define C1_OVERSAMPLE_SELECT 15
`define C1_RELEASE_LSB       16
`define C1_ASSERT_LSB        21
`define C1_RESET             32'h0000_0000
`define C1_WRITE_MASK        32'h03ff_fffd
// Control two and three fields
`define C2_MATCH_LSB         24
`define C3_DRIVER_FUNC       14
// Event state and flag clear bit positions
`define ST_PARITY_ERR        0
`define ST_OVERRUN           3
`define ST_IDLE_SEEN         4
`define ST_RX_FULL           5
`define ST_TX_DONE           6
`define ST_TX_EMPTY          7
`define ST_CHAR_MATCH        17
`define ST_MUTED             19
// Action request bits
`define RQ_MUTE              2
`define RQ_RX_FLUSH          3
// Sample timing
`define OSR16_LAST           4'hf
`define OSR8_LAST            4'h7
`define OSR16_HALF           4'h7
`define OSR8_HALF            4'h3
`define IDLE_BITS_LAST       4'h9
`endif

// file: sim/uart_control_one_and_map_bench.sv
`timescale 1ns/1ps
module uart_control_one_and_map_bench;
	localparam int BIT = 16;
	localparam logic [31:0] OSR8 = 32'h0000_8000;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        nine = 1'b0;
	logic        send_go = 1'b0;
	logic        ign = 1'b0;
	logic [8:0]  send_data = 9'h0;
	wire  [31:0] prdata;
	wire         pready, pslverr, rx_line, tx_line, line_driver_on, irq, got;
	wire  [8:0]  got_data;
	wire  [3:0]  obs = {got, irq, tx_line, line_driver_on};
	logic [31:0] rv, cfg, we, wm, st, exp_q[$], msk_q[$];
	logic [8:0]  d, ser_q[$];
	logic [2:0]  c;
	int          fail_count = 0;
	int          n_tests = 0;
	int          n;
	event        stop_ev;

	always #25 core_clk = ~core_clk;

	uart_control_one_and_map uart_control_one_and_map_inst (.core_clk(core_clk), .reset_n(reset_n),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line),
		.line_driver_on(line_driver_on), .irq(irq));
	uart_far_end #(.BIT(BIT)) uart_far_end_inst (.core_clk(core_clk), .tx_line(tx_line), .rx_line(rx_line),
		.nine(nine), .send_go(send_go), .send_data(send_data), .got(got), .got_data(got_data));

	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		n_tests++;
		if (got_v !== exp_v) begin
			$display("ERROR at %0t: got %h expected %h", $time, got_v, exp_v);
			fail_count++;
		end
	endtask

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Hold everything until pready is seen high; a zero mask only walks the map
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv, input logic [31:0] e,
		input logic [31:0] m);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dv;
		if (!w) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rv = prdata;
		if (k >= 20) begin
			fail_count++;
			-> stop_ev;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_bit(input int i, input logic v, input int lim);
		n = 0;
		while (obs[i] !== v && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= lim) begin
			fail_count++;
			-> stop_ev;
		end
	endtask

	function automatic logic [8:0] frame(input logic [8:0] dv, input logic [2:0] cc);
		logic [8:0] v;
		v = cc[2] ? dv : {1'b0, dv[7:0]};
		if (cc[1] && cc[2]) v[8] = ^v[7:0] ^ cc[0];
		if (cc[1] && !cc[2]) v[7] = ^v[6:0] ^ cc[0];
		return v;
	endfunction

	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			wm = msk_q.pop_front();
			we = exp_q.pop_front();
			if (wm != 0) chk(prdata & wm, we & wm);
		end
		if (got === 1'b1 && !ign) chk({23'h0, got_data}, {23'h0, ser_q.pop_front()});
	end

	initial begin
		@(stop_ev);
		test_done();
	end

	initial begin
		void'($urandom(68));
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		apb(0, 8'h00, 0, 0, ALL);
		for (int a = 0; a < 44; a += 4) apb(0, 8'(a), 0, (a == 28) ? 32'h80 : 0, ALL);
		apb(1, 8'h00, ALL - 1, 0, 0);
		apb(0, 8'h00, 0, 32'h03ff_fffc, ALL);
		apb(1, 8'h00, 0, 0, 0);
		apb(1, 8'h0c, 1, 0, 0);
		apb(0, 8'h0c, 0, 1, 32'hffff);
		// Parity and length only change with the unit off
		for (int k = 0; k < 4; k++) begin
			c = {k == 3, k != 0, k == 2};
			cfg = OSR8 | 32'h48 | {c[2], 1'b0, c[1], c[0], 9'h0};
			apb(1, 8'h00, cfg, 0, 0);
			apb(1, 8'h00, cfg | 1, 0, 0);
			nine <= c[2];
			d = 9'($urandom);
			ser_q.push_back(frame(d, c));
			apb(1, 8'h28, {23'h0, d}, 0, 0);
			wait_bit(3, 1, 400);
			repeat (2 * BIT) @(posedge core_clk);
			chk(irq, 1);
			apb(1, 8'h20, 32'h40, 0, 0);
			repeat (2) @(posedge core_clk);
			chk(irq, 0);
		end
		apb(1, 8'h00, 0, 0, 0);
		apb(1, 8'h08, 32'h4000, 0, 0);
		apb(1, 8'h00, OSR8 | 32'h0062_0008, 0, 0);
		apb(1, 8'h00, OSR8 | 32'h0062_0009, 0, 0);
		nine <= 1'b0;
		ser_q.push_back(9'h05a);
		apb(1, 8'h28, 32'h5a, 0, 0);
		wait_bit(0, 1, 100);
		wait_bit(1, 0, 100);
		chk(n >= 5 && n <= 9, 1);
		wait_bit(0, 0, 400);
		chk(n >= 161 && n <= 167, 1);
		apb(1, 8'h08, 0, 0, 0);
		cfg = OSR8 | 32'h88;
		apb(1, 8'h00, cfg, 0, 0);
		apb(1, 8'h00, cfg | 1, 0, 0);
		repeat (4) @(posedge core_clk);
		chk(irq, 1);
		ign <= 1'b1;
		// Zero data keeps the line low mid-frame; a second word leaves the buffer full
		apb(1, 8'h28, 32'h100, 0, 0);
		repeat (3 * BIT) @(posedge core_clk);
		apb(1, 8'h28, 32'h100, 0, 0);
		chk(tx_line, 0);
		apb(1, 8'h00, cfg, 0, 0);
		repeat (2) @(posedge core_clk);
		chk(tx_line, 1);
		apb(0, 8'h1c, 0, 32'h80, 32'h000a_00f9);
		apb(0, 8'h00, 0, cfg, ALL);
		repeat (12 * BIT) @(posedge core_clk);
		ign <= 1'b0;
		apb(1, 8'h04, 32'ha500_0000, 0, 0);
		// Plain, receiver off, odd parity with match and idle, then mute with idle wakeup
		for (int k = 0; k < 4; k++) begin
			cfg = OSR8 | ((k == 2) ? 32'h4734 : (k == 3) ? 32'h2024 : 32'h24);
			apb(1, 8'h00, cfg, 0, 0);
			apb(1, 8'h00, (k == 1) ? cfg - 3 : cfg | 1, 0, 0);
			if (k == 3) apb(1, 8'h18, 32'h4, 0, 0);
			send_data <= 9'h0a5;
			send_go <= 1'b1;
			@(posedge core_clk);
			send_go <= 1'b0;
			repeat (12 * BIT) @(posedge core_clk);
			st = (k == 1) ? 32'h0 : (k == 3) ? 32'h0008_0000 : 32'h0002_0020 | 32'(k == 2);
			apb(0, 8'h1c, 0, st, 32'h000a_0021);
			if (k == 0 || k == 2) chk(irq, 1);
			if (k == 0 || k == 2) apb(0, 8'h24, 0, 32'h0a5, 32'h1ff);
			if (k == 2) chk(irq, 1);
			if (k == 2) apb(1, 8'h20, 32'h0002_0001, 0, 0);
			repeat (2) @(posedge core_clk);
			chk(irq, 0);
			if (k == 2) wait_bit(2, 1, 300);
			if (k == 3) repeat (10 * BIT) @(posedge core_clk);
			if (k == 3) apb(0, 8'h1c, 0, 32'h0, 32'h0008_0000);
		end
		-> stop_ev;
	end
endmodule

// file: sim/uart_far_end.sv
`timescale 1ns/1ps
module uart_far_end #(
	parameter int BIT = 16
) (
	// Clock
	input  wire logic       core_clk,
	// Serial link
	input  wire logic       tx_line,
	output logic            rx_line,
	// Bench side
	input  wire logic       nine,
	input  wire logic       send_go,
	input  wire logic [8:0] send_data,
	output logic            got,
	output logic [8:0]      got_data
);
	logic [8:0] d;
	initial begin
		rx_line = 1'b1;
		got = 1'b0;
		got_data = 9'h0;
	end
	// Mid-bit sampling tolerates a clock of skew
	always begin
		@(negedge tx_line);
		d = 9'h0;
		repeat (BIT / 2) @(posedge core_clk);
		for (int i = 0; i < (nine ? 9 : 8); i++) begin
			repeat (BIT) @(posedge core_clk);
			d[i] = tx_line;
		end
		repeat (BIT) @(posedge core_clk);
		got_data <= d;
		got <= tx_line;
		@(posedge core_clk);
		got <= 1'b0;
	end
	// Line idles high between frames
	always begin
		@(posedge core_clk);
		if (send_go) begin
			rx_line <= 1'b0;
			for (int j = 0; j < 11; j++) begin
				repeat (BIT) @(posedge core_clk);
				rx_line <= (j < 8) ? send_data[j] : 1'b1;
			end
		end
	end
endmodule

// file: sim/uart_map_monitor.sv
`timescale 1ns/1ps
module uart_map_monitor (
	// Clock and reset
	input wire        core_clk,
	input wire        reset_n,
	// Register bus
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Line and request
	input wire        tx_line,
	input wire        line_driver_on,
	input wire        irq
);
	logic [31:0] ctl_q;
	logic        drv_q;
	wire         wr_done = psel && penable && pready && pwrite;
	wire         mapped  = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};

	// Shadow of the settings, so checks need no peek inside
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_q <= 32'h0000_0000;
			drv_q <= 1'b0;
		end else if (wr_done && paddr == 8'h00) begin
			ctl_q <= pwdata & 32'h03ff_fffd;
		end else if (wr_done && paddr == 8'h08) begin
			drv_q <= pwdata[14];
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	ready_after_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("bus answer late");
	ready_one_pulse_a: assert property (pready |=> !pready)
		else $error("bus answer too long");
	slverr_decode_a: assert property (pready |-> pslverr == !mapped && (!pslverr || prdata == 32'h0))
		else $error("bus error decode wrong");
	ctl_readback_a: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == ctl_q)
		else $error("control read wrong");
	off_no_irq_a: assert property ((!ctl_q[0]) [*2] |-> !irq)
		else $error("request while off");
	off_line_idle_a: assert property ((!ctl_q[0]) [*2] |-> tx_line && !line_driver_on)
		else $error("line active while off");
	masked_no_irq_a: assert property ((ctl_q[8:4] == 5'h0 && !ctl_q[14]) [*2] |-> !irq)
		else $error("request while masked");
	driver_frame_a: assert property (drv_q && !tx_line |-> line_driver_on)
		else $error("frame without driver");
	driver_unused_a: assert property ((!drv_q) [*2] |-> !line_driver_on)
		else $error("driver on while unused");

	cover property (wr_done && paddr == 8'h28);
	cover property ($rose(line_driver_on));
	cover property (pready && pslverr);
endmodule

bind uart_control_one_and_map uart_map_monitor uart_map_monitor_inst (.core_clk(core_clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_line(tx_line), .line_driver_on(line_driver_on), .irq(irq));
